// File: hw/mrc_mem.sv
// 64 x 12 mode register storage with registered read port
// assumes single clock, write and read on the same edge allowed
`timescale 1ns/1ps
module mrc_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 12
) (
  input wire logic pclk, // clock
  input wire logic we, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] waddr, // write index
  input wire logic [WIDTH-1:0] wdata, // write data
  input wire logic [$clog2(DEPTH)-1:0] raddr, // read index
  output logic [WIDTH-1:0] rdata // registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];
  if (DEPTH < 2) begin : g_depth_check
    $error("depth too small");
  end
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule

// File: hw/mrc_shadow.sv
// pending bank for the frequency dependent registers, one slot each
// assumes capture and flush may coincide for the same slot; capture wins over flush
`timescale 1ns/1ps
module mrc_shadow #(
  parameter int SLOTS = 6
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic cap, // capture a deferred write
  input wire logic [2:0] cap_slot, // slot to capture
  input wire logic [11:0] cap_op, // operand
  input wire logic flush, // end of drain, clear all pending
  output logic [SLOTS-1:0] pend, // slot holds an update
  output logic [11:0] slot_op [SLOTS] // held operands
);
  if (SLOTS > 8) begin : g_slot_check
    $error("slot index too narrow");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        if (cap && cap_slot == 3'(i)) begin
          pend[i] <= 1'b1;
        end else if (flush) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge pclk) begin
    if (cap) begin
      slot_op[cap_slot] <= cap_op;
    end
  end
endmodule

// File: hw/mrc_top.sv
// mode register control: mode register set decode, deferral, calibration timing
// assumes an APB master and command strobes from the command decoder on pclk
`timescale 1ns/1ps
`include "mrc_map.svh"
module mrc_top #(
  parameter logic SEV_PIN_SUPPORTED = 1'b1,
  parameter logic LANE_HZ_SUPPORTED = 1'b1,
  parameter logic WCK_CAL_SUPPORTED = 1'b1
) (
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic refresh_all, // all bank refresh latched, pulse
  input wire logic sr_sleep_entry, // self refresh sleep entry, pulse
  input wire logic sleep_entry, // sleep mode entry, pulse
  input wire logic hib_exit, // hibernate sleep exit, pulse
  output mrc_pkg::mrc_ctl_t ctl, // applied control fields
  output logic hib_enter, // enter hibernate, pulse
  output logic cal_update, // calibration update in progress
  output logic mrs_busy // mode update window open
);
  import mrc_pkg::*;

  // windows round up to whole clock cycles
  localparam int MOD_CYC = (`MRC_MOD_NS * `MRC_CLK_MHZ + 999) / 1000;
  localparam int KO_CYC = (`MRC_KO_NS * `MRC_CLK_MHZ + 999) / 1000;
  localparam int CW = 8;

  // cnt is CW bits wide; a faster clock or longer windows need a wider counter
  if (MOD_CYC < 1 || MOD_CYC > 255) begin : g_mod_check
    $error("mode update count out of range");
  end
  if (KO_CYC < 1 || KO_CYC > 255) begin : g_ko_check
    $error("calibration count out of range");
  end
  // the pending bank has exactly one slot per frequency dependent register
  if (`MRC_IDX_FD_HI - `MRC_IDX_FD_LO != 5) begin : g_fd_check
    $error("pending bank expects six frequency registers");
  end

  logic freq_dependent_defer_flag;
  mrc_state_t state;
  mrc_state_t next_state;
  logic [CW-1:0] cnt;
  logic [5:0] wr_idx;
  logic [11:0] wr_op;
  logic wr_en;
  logic apply_en;
  logic [5:0] apply_idx;
  logic [11:0] apply_op;
  logic [11:0] mem_rdata;
  logic [5:0] rd_idx;
  logic [5:0] pend;
  logic [11:0] slot_op [6];
  logic flush;
  logic flush_d;
  logic [2:0] fl_ptr;
  logic fl_run;
  logic fl_hit;
  logic apb_done;
  logic at_cmd;
  logic at_read;
  logic [11:0] rd_word;
  logic [11:0] mr5;
  logic [11:0] mr8;
  logic [11:0] mr0;
  logic apb_acc;
  logic apb_wr;
  logic is_fd;
  logic abi_change;
  mrc_cmd_t cmd;

  function automatic logic fd_reg(input logic [5:0] idx);
    fd_reg = idx >= `MRC_IDX_FD_LO && idx <= `MRC_IDX_FD_HI;
  endfunction

  // pready is a flop, so the edge that raises it is not the completion edge;
  // writes land only at the edge where the master sees pready high
  assign apb_acc = psel && penable && !pready;
  assign apb_done = psel && penable && pready;
  assign at_cmd = paddr == `MRC_OFF_CMD;
  assign at_read = paddr == `MRC_OFF_READ;
  assign apb_wr = apb_done && pwrite && at_cmd;
  assign cmd = mrc_cmd_t'(pwdata[17:0]);
  assign is_fd = fd_reg(cmd.idx);
  assign abi_change = cmd.idx == `MRC_IDX_MR0 && cmd.op[`MRC_BIT_ABI] != mr0[`MRC_BIT_ABI];

  // deferred writes go to the pending bank instead of live state
  assign wr_en = apb_wr && !(is_fd && !freq_dependent_defer_flag);
  assign wr_idx = cmd.idx;
  assign wr_op = cmd.op;

  // pending slots drain one per cycle after a sleep entry
  assign flush = sleep_entry || sr_sleep_entry;
  assign fl_hit = fl_run && pend[fl_ptr];
  assign apply_en = wr_en || fl_hit;
  assign apply_idx = wr_en ? wr_idx : 6'(`MRC_IDX_FD_LO + 6'(fl_ptr));
  assign apply_op = wr_en ? wr_op : slot_op[fl_ptr];

  mrc_shadow #(
    .SLOTS(6)
  ) u_shadow (
    .pclk(pclk),
    .presetn(presetn),
    .cap(apb_wr && is_fd && !freq_dependent_defer_flag),
    .cap_slot(3'(cmd.idx - `MRC_IDX_FD_LO)),
    .cap_op(cmd.op),
    .flush(flush_d),
    .pend(pend),
    .slot_op(slot_op)
  );

  // array read data lag rd_idx by one clock; the wait state hides that
  mrc_mem #(
    .DEPTH(`MRC_NUM_MR),
    .WIDTH(12)
  ) u_mem (
    .pclk(pclk),
    .we(apply_en),
    .waddr(apply_idx),
    .wdata(apply_op),
    .raddr(rd_idx),
    .rdata(mem_rdata)
  );

  // drain walker; live writes take priority, the walker holds on the slot and retries it next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_run <= 1'b0;
      fl_ptr <= 3'h0;
      flush_d <= 1'b0;
    end else begin
      flush_d <= 1'b0;
      if (flush && !fl_run) begin
        fl_run <= 1'b1;
        fl_ptr <= 3'h0;
      end else if (fl_run && !(wr_en && pend[fl_ptr])) begin
        if (fl_ptr == 3'h5) begin
          fl_run <= 1'b0;
          flush_d <= 1'b1;
        end else begin
          fl_ptr <= fl_ptr + 3'h1;
        end
      end
    end
  end

  // live copies of the registers whose fields steer the block
  // none of them is frequency dependent, so deferral never touches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr0 <= `MRC_RST_ZERO;
      mr5 <= `MRC_RST_MR5;
      mr8 <= `MRC_RST_ZERO;
      freq_dependent_defer_flag <= 1'b0;
    end else begin
      if (apply_en && apply_idx == `MRC_IDX_MR0) begin
        mr0 <= apply_op;
        freq_dependent_defer_flag <= apply_op[`MRC_BIT_FD];
      end
      if (apply_en && apply_idx == `MRC_IDX_MR5) begin
        mr5 <= apply_op;
      end
      if (hib_exit) begin
        mr8[`MRC_BIT_HIB] <= 1'b0;
      end else if (apply_en && apply_idx == `MRC_IDX_MR8) begin
        mr8 <= apply_op;
      end
    end
  end

  // applied controls, registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0;
      ctl.cal_drv <= 1'b1;
      ctl.cal_term <= 1'b1;
      ctl.cal_wck <= WCK_CAL_SUPPORTED;
    end else begin
      ctl.test_mode <= mr0[`MRC_BIT_TEST];
      ctl.pam3 <= mr0[`MRC_BIT_PAM3];
      ctl.abi <= mr0[`MRC_BIT_ABI];
      ctl.cal_drv <= mr5[`MRC_BIT_CAL_DRV];
      ctl.cal_term <= mr5[`MRC_BIT_CAL_ALL];
      ctl.cal_wck <= mr5[`MRC_BIT_CAL_ALL] && mr5[`MRC_BIT_CAL_WCK]
                     && WCK_CAL_SUPPORTED;
      ctl.sev_on_err <= mr5[`MRC_BIT_SEV2PIN] && SEV_PIN_SUPPORTED;
      ctl.lane_hz <= mr5[`MRC_BIT_LANE_HZ] && LANE_HZ_SUPPORTED;
      ctl.hib_armed <= mr8[`MRC_BIT_HIB];
      ctl.sr_temp <= mr8[`MRC_BIT_SR_TEMP];
    end
  end

  // taken from the live bit, so a write just before entry still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hib_enter <= 1'b0;
    end else begin
      hib_enter <= sr_sleep_entry && mr8[`MRC_BIT_HIB];
    end
  end

  // mode update window and calibration window share one counter
  always_comb begin
    next_state = state;
    unique case (state)
      MRC_IDLE: begin
        if (refresh_all && (mr5[`MRC_BIT_CAL_ALL] || mr5[`MRC_BIT_CAL_DRV])) begin
          next_state = MRC_CAL;
        end else if (apb_wr) begin
          // every mode set opens the window, deferred or not; drained slots
          // apply during sleep, when the command bus is quiet anyway
          next_state = MRC_WAIT;
        end
      end
      MRC_WAIT: begin
        if (cnt == CW'(1)) begin
          next_state = MRC_IDLE;
        end
      end
      MRC_CAL: begin
        if (cnt == CW'(1)) begin
          next_state = MRC_IDLE;
        end
      end
      default: next_state = MRC_IDLE;
    endcase
  end

  // one counter serves both windows; a refresh in idle wins over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MRC_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      if (state == MRC_IDLE && next_state == MRC_CAL) begin
        cnt <= CW'(KO_CYC);
      end else if (state == MRC_IDLE && next_state == MRC_WAIT) begin
        cnt <= CW'(MOD_CYC);
      end else if (cnt != '0) begin
        cnt <= cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_update <= 1'b0;
      mrs_busy <= 1'b0;
    end else begin
      cal_update <= next_state == MRC_CAL;
      // an inversion change shows at once, even while the counter is taken
      mrs_busy <= next_state == MRC_WAIT || (apb_wr && abi_change);
    end
  end

  // apb: one wait state, reads other than mr0, mr5 and mr8 go through the registered memory port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx <= '0;
    end else begin
      if (apb_wr) begin
        rd_idx <= cmd.idx;
      end else if (apb_done && pwrite && at_read) begin
        rd_idx <= pwdata[5:0];
      end
    end
  end

  // live copies answer for their own registers, so the reset value of mr5 and
  // the self clearing hibernate bit read back without a reset of the array
  always_comb begin
    case (rd_idx)
      `MRC_IDX_MR0: rd_word = mr0;
      `MRC_IDX_MR5: rd_word = mr5;
      `MRC_IDX_MR8: rd_word = mr8;
      default: rd_word = mem_rdata;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= '0;
      if (apb_acc) begin
        if (!pwrite) begin
          unique case (paddr)
            `MRC_OFF_CMD: prdata <= {26'h0, rd_idx};
            `MRC_OFF_STAT: prdata <= {20'h0, state == MRC_CAL, state == MRC_WAIT,
                                      freq_dependent_defer_flag, fl_run, 2'h0, pend};
            `MRC_OFF_READ: prdata <= {20'h0, rd_word};
            `MRC_OFF_CAP: prdata <= {26'h0, LANE_HZ_SUPPORTED, 4'h0,
                                     SEV_PIN_SUPPORTED};
            default: pslverr <= 1'b1;
          endcase
        // unmapped offsets answer with an error so the master never stalls
        end else if (!at_cmd && !at_read) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// File: pkg/mrc_map.svh
// register indices, field positions, reset values, apb offsets and timing in ns and MHz
// assumes inclusion by the top module only
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH
`define MRC_IDX_MR0 6'h00
`define MRC_IDX_MR5 6'h05
`define MRC_IDX_MR8 6'h08
`define MRC_IDX_FD_LO 6'h0a
`define MRC_IDX_FD_HI 6'h0f
`define MRC_NUM_MR 64
`define MRC_BIT_ABI 0
`define MRC_BIT_RD_CRC 3
`define MRC_BIT_WR_CRC 4
`define MRC_BIT_TEST 7
`define MRC_BIT_PAM3 8
`define MRC_BIT_SEV 9
`define MRC_BIT_POISON 10
`define MRC_BIT_FD 11
`define MRC_BIT_CAL_WCK 7
`define MRC_BIT_CAL_ALL 8
`define MRC_BIT_SEV2PIN 9
`define MRC_BIT_LANE_HZ 10
`define MRC_BIT_CAL_DRV 11
`define MRC_BIT_SR_TEMP 9
`define MRC_BIT_HIB 11
`define MRC_RST_MR5 12'h980
`define MRC_RST_ZERO 12'h000
`define MRC_MOD_NS 15
`define MRC_KO_NS 40
`define MRC_CLK_MHZ 250
`define MRC_OFF_CMD 12'h000
`define MRC_OFF_STAT 12'h004
`define MRC_OFF_READ 12'h008
`define MRC_OFF_CAP 12'h00c
`endif

// File: pkg/mrc_pkg.sv
// types shared by the mode register control block
// assumes mrc_map.svh for numeric constants
package mrc_pkg;
  typedef struct packed {
    logic [5:0] idx;
    logic [11:0] op;
  } mrc_cmd_t;
  typedef struct packed {
    logic test_mode;
    logic pam3;
    logic abi;
    logic cal_drv;
    logic cal_term;
    logic cal_wck;
    logic sev_on_err;
    logic lane_hz;
    logic hib_armed;
    logic sr_temp;
  } mrc_ctl_t;
  typedef enum logic [2:0] {
    MRC_IDLE = 3'b001,
    MRC_WAIT = 3'b010,
    MRC_CAL = 3'b100
  } mrc_state_t;
endpackage

// File: test/mrc_chk.sv
// checker: timing relations at the mode register control ports
// assumes a bind onto mrc_top, one clock domain
`timescale 1ns/1ps
module mrc_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic refresh_all, // refresh pulse
  input wire logic sr_sleep_entry, // self refresh entry
  input wire logic hib_exit, // hibernate exit
  input wire mrc_pkg::mrc_ctl_t ctl, // applied fields
  input wire logic hib_enter, // hibernate entry
  input wire logic cal_update, // calibration window
  input wire logic mrs_busy // mode window
);
  import mrc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_cal_len;
    $rose(cal_update) |-> cal_update[*8] ##1 cal_update ##1 cal_update ##1 !cal_update;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration window length");
  property p_cal_src; $rose(cal_update) |-> $past(refresh_all); endproperty
  a_cal_src: assert property (p_cal_src) else $error("calibration without refresh");
  property p_busy_len; $rose(mrs_busy) |-> mrs_busy[*4] ##1 !mrs_busy; endproperty
  a_busy_len: assert property (p_busy_len) else $error("mode window length");
  property p_busy_src;
    $rose(mrs_busy) |-> $past(pready && pwrite && paddr == 12'h000);
  endproperty
  a_busy_src: assert property (p_busy_src) else $error("mode window without write");
  property p_hib_go; sr_sleep_entry && ctl.hib_armed |=> hib_enter; endproperty
  a_hib_go: assert property (p_hib_go) else $error("hibernate not entered");
  property p_hib_src; hib_enter |-> $past(sr_sleep_entry); endproperty
  a_hib_src: assert property (p_hib_src) else $error("hibernate without entry");
  property p_hib_clr; hib_exit |-> ##[1:3] !ctl.hib_armed; endproperty
  a_hib_clr: assert property (p_hib_clr) else $error("hibernate bit kept");
  property p_ctl_src;
    $changed({ctl.test_mode, ctl.pam3, ctl.abi, ctl.sev_on_err, ctl.lane_hz})
      |-> $past(pready, 1) || $past(pready, 2) || $past(pready, 3);
  endproperty
  a_ctl_src: assert property (p_ctl_src) else $error("fields changed without write");
  c_cal: cover property ($rose(cal_update));
  c_hib: cover property (hib_enter);
  c_busy: cover property ($rose(mrs_busy));
endmodule

// File: test/mrc_host.sv
// host side model: refresh and sleep command pulses on pclk
// assumes the testbench calls send from one process at a time
`timescale 1ns/1ps
module mrc_host (
  input wire logic pclk, // clock
  input wire logic cal_update, // calibration window
  input wire logic mrs_busy, // mode window
  output logic refresh_all, // all bank refresh
  output logic sr_sleep_entry, // self refresh entry
  output logic sleep_entry, // sleep entry
  output logic hib_exit // hibernate exit
);
  logic [3:0] cmd;
  assign {hib_exit, sleep_entry, sr_sleep_entry, refresh_all} = cmd;
  initial cmd = 4'h0;
  // only nops while a window is open, so wait it out
  task send(input int k);
    @(posedge pclk);
    while (cal_update === 1'b1 || mrs_busy === 1'b1) @(posedge pclk);
    cmd <= 4'h1 << k;
    @(posedge pclk);
    cmd <= 4'h0;
  endtask
endmodule

// File: test/tb_top.sv
// testbench: apb master, command model and checks of mrc_top
// assumes mrc_pkg and mrc_map.svh are compiled ahead
`timescale 1ns/1ps
module tb_top;
  import mrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic refresh_all, sr_sleep_entry, sleep_entry, hib_exit, hib_enter, cal_update, mrs_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mrc_ctl_t ctl;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  mrc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refresh_all(refresh_all), .sr_sleep_entry(sr_sleep_entry),
    .sleep_entry(sleep_entry), .hib_exit(hib_exit), .ctl(ctl), .hib_enter(hib_enter),
    .cal_update(cal_update), .mrs_busy(mrs_busy));
  mrc_host host_u (.pclk(pclk), .cal_update(cal_update), .mrs_busy(mrs_busy),
    .refresh_all(refresh_all), .sr_sleep_entry(sr_sleep_entry),
    .sleep_entry(sleep_entry), .hib_exit(hib_exit));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mr_wr(input logic [5:0] i, input logic [11:0] op);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {14'h0, i, op});
    repeat (8) begin
      @(posedge pclk);
      if (mrs_busy === 1'b1) n++;
    end
    chk(n, 4);
  endtask
  task mr_rd(input logic [5:0] i, input logic [11:0] exp);
    apb(1'b1, 12'h008, {26'h0, i});
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & 32'hfff, {20'h0, exp});
  endtask
  task cnt(input logic hib, output int n);
    n = 0;
    repeat (24) begin
      @(posedge pclk);
      if ((hib ? hib_enter : cal_update) === 1'b1) n++;
    end
  endtask
  function automatic logic [2:0] exp0(input logic [11:0] op);
    return {op[7], op[8], op[0]};
  endfunction
  function automatic logic [4:0] exp5(input logic [11:0] op);
    return {op[11], op[8], op[7] & op[8], op[9], op[10]};
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    logic [11:0] op;
    int n;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'hd73e8469));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({29'h0, ctl.cal_drv, ctl.cal_term, ctl.cal_wck}, 32'h7);
    mr_rd(6'h05, 12'h980);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(rd & 32'h20, 32'h20);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      op = 12'($urandom);
      mr_wr(6'h00, op);
      chk({29'h0, ctl.test_mode, ctl.pam3, ctl.abi}, {29'h0, exp0(op)});
      mr_rd(6'h00, op);
    end
    mr_wr(6'h00, 12'h200);
    for (int k = 0; k < 6; k++) begin
      op = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : 12'($urandom);
      mr_wr(6'h05, op);
      chk({27'h0, ctl.cal_drv, ctl.cal_term, ctl.cal_wck, ctl.sev_on_err, ctl.lane_hz},
        {27'h0, exp5(op)});
      host_u.send(0);
      cnt(1'b0, n);
      chk(n, (op[8] | op[11]) ? 10 : 0);
    end
    op = 12'($urandom);
    mr_wr(6'h0c, ~op);
    mr_wr(6'h0e, op);
    mr_wr(6'h0c, op ^ 12'h5a5);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3f, 32'h14);
    host_u.send(2);
    repeat (20) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3f, 32'h0);
    mr_rd(6'h0c, op ^ 12'h5a5);
    mr_rd(6'h0e, op);
    mr_wr(6'h00, 12'ha00);
    mr_wr(6'h0b, ~op);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3f, 32'h0);
    mr_rd(6'h0b, ~op);
    mr_wr(6'h08, 12'ha00);
    chk({30'h0, ctl.hib_armed, ctl.sr_temp}, 32'h3);
    host_u.send(1);
    cnt(1'b1, n);
    chk(n, 1);
    host_u.send(3);
    repeat (4) @(posedge pclk);
    chk({31'h0, ctl.hib_armed}, 32'h0);
    mr_rd(6'h08, 12'h200);
    final_report();
  end
endmodule
bind mrc_top mrc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .refresh_all(refresh_all), .sr_sleep_entry(sr_sleep_entry), .hib_exit(hib_exit),
  .ctl(ctl), .hib_enter(hib_enter), .cal_update(cal_update), .mrs_busy(mrs_busy));
